// file: design/vap_pkg.sv
// Notes on behaviour
// - A cleared plane-enable bit forces that plane's colour bit to zero.
// - Status-mux code picks palette bit pair shown on input status bits 5:4.
// - Horizontal pixel shift field shifts the image left, text and graphics.
// - Nine-dot text: codes 0-7 shift code plus one, code 8 no shift.
// - Eight-dot text and 16-colour graphics: codes 0-7 shift by code value.
// - 8-bit assembly mode: even codes 0,2,4,6 shift by 0 to 3 pixels.
// - Colour-select bits 3:2 supply index bits seven and six for 16 colours.
// - Colour-select bits 1:0 replace bits five and four when mode bit 7 set.
// - Indexed mode: 8-bit index picks one of 256 entries of 24 bits.
// - Direct mode: pixel data drives red, green and blue bypassing the table.
// - Table reached only via data port 3C9h and index registers 3C7h, 3C8h.
// - Three data reads return red, green, blue; third read bumps read index.
// - Written entry commits only after the third byte, never earlier.
// - Third written byte increments the write index.
// - Eight cursor entries use the same scheme when the alternate set is on.
// - Indexed mode ANDs each pixel index with the pixel mask register.
// - Direct mode ignores the pixel mask register.
// - State register bits 1:0 read 00 after write index; bits 7:2 read zero.
// - State register reads 11 when the read index was written last.
// - Writing either index resets the byte sequencer to red.
`default_nettype none
package vap_pkg;
    localparam logic [15:0] VAP_ATTR_WR_ADDR = 16'h03c0;
    localparam logic [15:0] VAP_ATTR_RD_ADDR = 16'h03c1;
    localparam logic [15:0] VAP_STAT_MONO_ADDR = 16'h03ba;
    localparam logic [15:0] VAP_STAT_COLOR_ADDR = 16'h03da;
    localparam logic [15:0] VAP_MASK_ADDR = 16'h03c6;
    localparam logic [15:0] VAP_RIDX_ADDR = 16'h03c7;
    localparam logic [15:0] VAP_WIDX_ADDR = 16'h03c8;
    localparam logic [15:0] VAP_DATA_ADDR = 16'h03c9;

    localparam logic [4:0] VAP_IDX_PAL_LAST = 5'h0f;
    localparam logic [4:0] VAP_IDX_MODE = 5'h10;
    localparam logic [4:0] VAP_IDX_PLANE = 5'h12;
    localparam logic [4:0] VAP_IDX_SHIFT = 5'h13;
    localparam logic [4:0] VAP_IDX_CSEL = 5'h14;

    localparam int VAP_VIDEN_BIT = 5;
    localparam int VAP_MODE_P54_BIT = 7;
    localparam int VAP_MODE_PIX8_BIT = 6;
    localparam int VAP_MODE_GFX_BIT = 0;
    localparam int VAP_STATMUX_LSB = 4;
    localparam int VAP_STAT_LO_BIT = 4;
    localparam int VAP_STAT_HI_BIT = 5;

    localparam logic [7:0] VAP_MASK_RST = 8'hff;
    localparam logic [7:0] VAP_ATTR_RST = 8'h00;
    localparam logic [7:0] VAP_ARX_MASK = 8'h3f;
    localparam logic [7:0] VAP_PLANE_MASK = 8'h3f;
    localparam logic [7:0] VAP_NIB_MASK = 8'h0f;
    localparam logic [7:0] VAP_MODE_MASK = 8'hef;
    localparam logic [1:0] VAP_STATE_WRITE = 2'b00;
    localparam logic [1:0] VAP_STATE_READ = 2'b11;
    localparam logic [3:0] VAP_SHIFT_MAX_CODE = 4'h7;

    typedef enum logic [2:0] {
        VAP_PH_RED = 3'b001,
        VAP_PH_GREEN = 3'b010,
        VAP_PH_BLUE = 3'b100
    } vap_phase_e;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] data;
    } vap_io_s;

    typedef struct packed {
        logic [3:0] planes;
        logic [7:0] index8;
        logic [23:0] direct;
        logic cursorOn;
        logic [2:0] cursorIdx;
    } vap_pix_s;

    typedef struct packed {
        logic [7:0] red;
        logic [7:0] green;
        logic [7:0] blue;
    } vap_rgb_s;
endpackage
`default_nettype wire

// file: design/vap_pan_shift.sv
`default_nettype none
// Drops the first N pixels of every line, which moves the picture left.
module vap_pan_shift (
    input wire logic clk,
    input wire logic reset,
    input wire logic pixEn,
    input wire logic lineStart,
    input wire logic [3:0] shiftCode,
    input wire logic nineDot,
    input wire logic pix8Mode,
    output logic pixKeep
);
    import vap_pkg::*;

    logic [3:0] skip_q;
    logic [3:0] skip_d;
    logic [3:0] amount;
    logic [3:0] cur;

    // Undefined table cells are given a shift of zero.
    always_comb begin
        amount = 4'h0;
        if (pix8Mode) begin
            if (!shiftCode[0] && shiftCode <= VAP_SHIFT_MAX_CODE) begin
                amount = {1'b0, shiftCode[3:1]};
            end
        end else if (nineDot) begin
            if (shiftCode <= VAP_SHIFT_MAX_CODE) begin
                amount = shiftCode + 4'h1;
            end
        end else if (shiftCode <= VAP_SHIFT_MAX_CODE) begin
            amount = shiftCode;
        end
    end

    always_comb begin
        cur = lineStart ? amount : skip_q;
        pixKeep = pixEn && (cur == 4'h0);
        skip_d = skip_q;
        if (pixEn) begin
            skip_d = (cur == 4'h0) ? 4'h0 : cur - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            skip_q <= 4'h0;
        end else begin
            skip_q <= skip_d;
        end
    end
endmodule
`default_nettype wire

// file: design/vap_attr_palette.sv
`default_nettype none
// Attribute tail, pixel mask and colour lookup table with its host port.
module vap_attr_palette #(
    parameter int TABLE_DEPTH = 256,
    parameter int CURSOR_DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire vap_pkg::vap_io_s ioReq,
    output logic [7:0] ioRdData,
    output logic ioRdValid,
    input wire logic pixEn,
    input wire logic lineStart,
    input wire vap_pkg::vap_pix_s pixIn,
    input wire logic directMode,
    input wire logic cursorTableSel,
    input wire logic nineDot,
    output vap_pkg::vap_rgb_s rgbOut,
    output logic rgbValid
);
    import vap_pkg::*;

    localparam int CW = $clog2(CURSOR_DEPTH);

    logic [23:0] colourTable [TABLE_DEPTH];
    logic [23:0] cursorTable [CURSOR_DEPTH];
    logic [5:0] attrPalette [16];

    logic [7:0] mask_q, mask_d;
    logic [7:0] arx_q, arx_d;
    logic arxData_q, arxData_d;
    logic [7:0] modeCtl_q, modeCtl_d;
    logic [7:0] planeCtl_q, planeCtl_d;
    logic [7:0] shiftCtl_q, shiftCtl_d;
    logic [7:0] colSel_q, colSel_d;
    logic [7:0] readIdx_q, readIdx_d;
    logic [7:0] writeIdx_q, writeIdx_d;
    vap_phase_e rdPhase_q, rdPhase_d;
    vap_phase_e wrPhase_q, wrPhase_d;
    logic lastWasRead_q, lastWasRead_d;
    logic [7:0] redHold_q, redHold_d;
    logic [7:0] greenHold_q, greenHold_d;
    logic [7:0] rdData_q, rdData_d;
    logic rdValid_q, rdValid_d;
    logic [7:0] palBits_q, palBits_d;
    vap_rgb_s rgb_q, rgb_d;
    logic rgbValid_q, rgbValid_d;

    logic tableWe;
    logic cursorWe;
    logic palWe;
    logic [23:0] commitVal;
    logic [23:0] rdEntry;
    logic [1:0] statSel;
    logic statLo, statHi;

    logic pixKeep;
    logic [3:0] planeBits;
    logic [5:0] attrLow;
    logic [7:0] attrIndex;
    logic [7:0] lookupIdx;

    vap_pan_shift u_pan (
        .clk(clk),
        .reset(reset),
        .pixEn(pixEn),
        .lineStart(lineStart),
        .shiftCode(shiftCtl_q[3:0]),
        .nineDot(nineDot && !modeCtl_q[VAP_MODE_GFX_BIT]),
        .pix8Mode(modeCtl_q[VAP_MODE_PIX8_BIT]),
        .pixKeep(pixKeep)
    );

    // Entry addressed by the host read sequence, from the selected set.
    always_comb begin
        if (cursorTableSel) begin
            rdEntry = cursorTable[readIdx_q[CW-1:0]];
        end else begin
            rdEntry = colourTable[readIdx_q];
        end
    end

    // Status mux routes two of the latched palette bits.
    always_comb begin
        statSel = planeCtl_q[VAP_STATMUX_LSB +: 2];
        case (statSel)
            2'b00: begin
                statHi = palBits_q[2];
                statLo = palBits_q[0];
            end
            2'b01: begin
                statHi = palBits_q[5];
                statLo = palBits_q[4];
            end
            2'b10: begin
                statHi = palBits_q[3];
                statLo = palBits_q[1];
            end
            default: begin
                statHi = palBits_q[7];
                statLo = palBits_q[6];
            end
        endcase
    end

    // Host port. The host sees read data one cycle after its strobe.
    always_comb begin
        mask_d = mask_q;
        arx_d = arx_q;
        arxData_d = arxData_q;
        modeCtl_d = modeCtl_q;
        planeCtl_d = planeCtl_q;
        shiftCtl_d = shiftCtl_q;
        colSel_d = colSel_q;
        readIdx_d = readIdx_q;
        writeIdx_d = writeIdx_q;
        rdPhase_d = rdPhase_q;
        wrPhase_d = wrPhase_q;
        lastWasRead_d = lastWasRead_q;
        redHold_d = redHold_q;
        greenHold_d = greenHold_q;
        rdData_d = 8'h00;
        rdValid_d = ioReq.rd;
        tableWe = 1'b0;
        cursorWe = 1'b0;
        palWe = 1'b0;
        commitVal = {redHold_q, greenHold_q, ioReq.data};
        if (ioReq.wr) begin
            if (ioReq.addr == VAP_ATTR_WR_ADDR) begin
                arxData_d = !arxData_q;
                if (!arxData_q) begin
                    arx_d = ioReq.data & VAP_ARX_MASK;
                end else if (arx_q[4:0] <= VAP_IDX_PAL_LAST) begin
                    palWe = !arx_q[VAP_VIDEN_BIT];
                end else if (arx_q[4:0] == VAP_IDX_MODE) begin
                    modeCtl_d = ioReq.data & VAP_MODE_MASK;
                end else if (arx_q[4:0] == VAP_IDX_PLANE) begin
                    planeCtl_d = ioReq.data & VAP_PLANE_MASK;
                end else if (arx_q[4:0] == VAP_IDX_SHIFT) begin
                    shiftCtl_d = ioReq.data & VAP_NIB_MASK;
                end else if (arx_q[4:0] == VAP_IDX_CSEL) begin
                    colSel_d = ioReq.data & VAP_NIB_MASK;
                end
            end else if (ioReq.addr == VAP_MASK_ADDR) begin
                mask_d = ioReq.data;
            end else if (ioReq.addr == VAP_RIDX_ADDR) begin
                readIdx_d = ioReq.data;
                lastWasRead_d = 1'b1;
                rdPhase_d = VAP_PH_RED;
                wrPhase_d = VAP_PH_RED;
            end else if (ioReq.addr == VAP_WIDX_ADDR) begin
                writeIdx_d = ioReq.data;
                lastWasRead_d = 1'b0;
                rdPhase_d = VAP_PH_RED;
                wrPhase_d = VAP_PH_RED;
            end else if (ioReq.addr == VAP_DATA_ADDR) begin
                case (wrPhase_q)
                    VAP_PH_RED: begin
                        redHold_d = ioReq.data;
                        wrPhase_d = VAP_PH_GREEN;
                    end
                    VAP_PH_GREEN: begin
                        greenHold_d = ioReq.data;
                        wrPhase_d = VAP_PH_BLUE;
                    end
                    default: begin
                        tableWe = !cursorTableSel;
                        cursorWe = cursorTableSel;
                        wrPhase_d = VAP_PH_RED;
                        if (cursorTableSel) begin
                            writeIdx_d = {{(8-CW){1'b0}},
                                writeIdx_q[CW-1:0] + {{(CW-1){1'b0}}, 1'b1}};
                        end else begin
                            writeIdx_d = writeIdx_q + 8'h01;
                        end
                    end
                endcase
            end
        end else if (ioReq.rd) begin
            if (ioReq.addr == VAP_ATTR_WR_ADDR) begin
                rdData_d = arx_q;
            end else if (ioReq.addr == VAP_ATTR_RD_ADDR) begin
                if (arx_q[4:0] <= VAP_IDX_PAL_LAST) begin
                    rdData_d = {2'b00, attrPalette[arx_q[3:0]]};
                end else if (arx_q[4:0] == VAP_IDX_MODE) begin
                    rdData_d = modeCtl_q;
                end else if (arx_q[4:0] == VAP_IDX_PLANE) begin
                    rdData_d = planeCtl_q;
                end else if (arx_q[4:0] == VAP_IDX_SHIFT) begin
                    rdData_d = shiftCtl_q;
                end else if (arx_q[4:0] == VAP_IDX_CSEL) begin
                    rdData_d = colSel_q;
                end
            end else if (ioReq.addr == VAP_STAT_MONO_ADDR ||
                         ioReq.addr == VAP_STAT_COLOR_ADDR) begin
                // Reading status also returns the 3C0h toggle to index.
                arxData_d = 1'b0;
                rdData_d[VAP_STAT_HI_BIT] = statHi;
                rdData_d[VAP_STAT_LO_BIT] = statLo;
            end else if (ioReq.addr == VAP_MASK_ADDR) begin
                rdData_d = mask_q;
            end else if (ioReq.addr == VAP_RIDX_ADDR) begin
                rdData_d = {6'h00, lastWasRead_q ? VAP_STATE_READ
                                                 : VAP_STATE_WRITE};
            end else if (ioReq.addr == VAP_DATA_ADDR) begin
                case (rdPhase_q)
                    VAP_PH_RED: begin
                        rdData_d = rdEntry[23:16];
                        rdPhase_d = VAP_PH_GREEN;
                    end
                    VAP_PH_GREEN: begin
                        rdData_d = rdEntry[15:8];
                        rdPhase_d = VAP_PH_BLUE;
                    end
                    default: begin
                        rdData_d = rdEntry[7:0];
                        rdPhase_d = VAP_PH_RED;
                        if (cursorTableSel) begin
                            readIdx_d = {{(8-CW){1'b0}},
                                readIdx_q[CW-1:0] + {{(CW-1){1'b0}}, 1'b1}};
                        end else begin
                            readIdx_d = readIdx_q + 8'h01;
                        end
                    end
                endcase
            end
        end
    end

    // Pixel path: attribute tail, mask, lookup, one register stage.
    always_comb begin
        planeBits = pixIn.planes & planeCtl_q[3:0];
        attrLow = attrPalette[planeBits];
        if (modeCtl_q[VAP_MODE_P54_BIT]) begin
            attrLow[5:4] = colSel_q[1:0];
        end
        if (modeCtl_q[VAP_MODE_PIX8_BIT]) begin
            attrIndex = pixIn.index8;
        end else begin
            attrIndex = {colSel_q[3:2], attrLow};
        end
        lookupIdx = attrIndex & mask_q;
        palBits_d = palBits_q;
        rgb_d = rgb_q;
        rgbValid_d = pixKeep;
        if (pixKeep) begin
            palBits_d = attrIndex;
            if (pixIn.cursorOn) begin
                rgb_d = cursorTable[pixIn.cursorIdx[CW-1:0]];
            end else if (directMode) begin
                rgb_d = pixIn.direct;
            end else begin
                rgb_d = colourTable[lookupIdx];
            end
        end
    end

    // Tables are not reset; their contents are undefined until loaded.
    always_ff @(posedge clk) begin
        if (tableWe) begin
            colourTable[writeIdx_q] <= commitVal;
        end
        if (cursorWe) begin
            cursorTable[writeIdx_q[CW-1:0]] <= commitVal;
        end
        if (palWe) begin
            attrPalette[arx_q[3:0]] <= ioReq.data[5:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= VAP_MASK_RST;
            arx_q <= VAP_ATTR_RST;
            arxData_q <= 1'b0;
            modeCtl_q <= VAP_ATTR_RST;
            planeCtl_q <= VAP_ATTR_RST;
            shiftCtl_q <= VAP_ATTR_RST;
            colSel_q <= VAP_ATTR_RST;
            readIdx_q <= 8'h00;
            writeIdx_q <= 8'h00;
            rdPhase_q <= VAP_PH_RED;
            wrPhase_q <= VAP_PH_RED;
            lastWasRead_q <= 1'b0;
            redHold_q <= 8'h00;
            greenHold_q <= 8'h00;
            rdData_q <= 8'h00;
            rdValid_q <= 1'b0;
            palBits_q <= 8'h00;
            rgb_q <= '0;
            rgbValid_q <= 1'b0;
        end else begin
            mask_q <= mask_d;
            arx_q <= arx_d;
            arxData_q <= arxData_d;
            modeCtl_q <= modeCtl_d;
            planeCtl_q <= planeCtl_d;
            shiftCtl_q <= shiftCtl_d;
            colSel_q <= colSel_d;
            readIdx_q <= readIdx_d;
            writeIdx_q <= writeIdx_d;
            rdPhase_q <= rdPhase_d;
            wrPhase_q <= wrPhase_d;
            lastWasRead_q <= lastWasRead_d;
            redHold_q <= redHold_d;
            greenHold_q <= greenHold_d;
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
            palBits_q <= palBits_d;
            rgb_q <= rgb_d;
            rgbValid_q <= rgbValid_d;
        end
    end

    assign ioRdData = rdData_q;
    assign ioRdValid = rdValid_q;
    assign rgbOut = rgb_q;
    assign rgbValid = rgbValid_q;
endmodule
`default_nettype wire

// file: tb/vap_attr_palette_assertions.sv
`default_nettype none
module vap_attr_palette_assertions (
    input wire logic clk,
    input wire logic reset,
    input wire vap_pkg::vap_io_s ioReq,
    input wire logic [7:0] ioRdData,
    input wire logic ioRdValid,
    input wire logic pixEn,
    input wire logic directMode,
    input wire vap_pkg::vap_pix_s pixIn,
    input wire vap_pkg::vap_rgb_s rgbOut,
    input wire logic rgbValid
);
    timeunit 1ns;
    timeprecision 1ns;
    import vap_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire rdOnly = ioReq.rd && !ioReq.wr;
    wire rdState = rdOnly && ioReq.addr == VAP_RIDX_ADDR;
    wire wrR = ioReq.wr && ioReq.addr == VAP_RIDX_ADDR;
    wire wrW = ioReq.wr && ioReq.addr == VAP_WIDX_ADDR;
    wire mapped = ioReq.addr inside {VAP_ATTR_WR_ADDR, VAP_ATTR_RD_ADDR,
        VAP_STAT_MONO_ADDR, VAP_STAT_COLOR_ADDR, VAP_MASK_ADDR,
        VAP_RIDX_ADDR, VAP_DATA_ADDR};
    sequence s_gap;
        !ioReq.wr ##1 rdState;
    endsequence
    property p_rd_answer;
        ioReq.rd |=> ioRdValid;
    endproperty
    property p_rd_only;
        !ioReq.rd |=> !ioRdValid;
    endproperty
    property p_state_read;
        wrR ##1 s_gap |=> ioRdData == {6'h00, VAP_STATE_READ};
    endproperty
    property p_state_write;
        wrW ##1 s_gap |=> ioRdData == {6'h00, VAP_STATE_WRITE};
    endproperty
    property p_state_high;
        rdState |=> ioRdData[7:2] == 6'h00;
    endproperty
    property p_unmapped;
        rdOnly && !mapped |=> ioRdData == 8'h00;
    endproperty
    property p_direct;
        rgbValid && $past(directMode) && !$past(pixIn.cursorOn)
            |-> rgbOut == $past(pixIn.direct);
    endproperty
    property p_pix_cause;
        rgbValid |-> $past(pixEn);
    endproperty
    property p_rgb_hold;
        !rgbValid |-> $stable(rgbOut);
    endproperty
    a_rd_answer: assert property (p_rd_answer)
        else $error("read gave no answer");
    a_rd_only: assert property (p_rd_only)
        else $error("answer without a read");
    a_state_read: assert property (p_state_read)
        else $error("state not 11 after read index write");
    a_state_write: assert property (p_state_write)
        else $error("state not 00 after write index write");
    a_state_high: assert property (p_state_high)
        else $error("state upper bits not zero");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_direct: assert property (p_direct)
        else $error("direct colour not passed through");
    a_pix_cause: assert property (p_pix_cause)
        else $error("colour out without a pixel");
    a_rgb_hold: assert property (p_rgb_hold)
        else $error("colour changed between pixels");
    c_state: cover property (wrR ##1 s_gap);
    c_direct: cover property (rgbValid && $past(directMode));
    c_index: cover property (rgbValid && !$past(directMode));
endmodule
bind vap_attr_palette vap_attr_palette_assertions chk (.clk(clk),
    .reset(reset), .ioReq(ioReq), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .pixEn(pixEn), .directMode(directMode),
    .pixIn(pixIn), .rgbOut(rgbOut), .rgbValid(rgbValid));
`default_nettype wire

// file: tb/vap_host_model.sv
`default_nettype none
module vap_host_model (
    input wire logic clk,
    output var vap_pkg::vap_io_s ioReq
);
    timeunit 1ns;
    timeprecision 1ns;
    import vap_pkg::*;
    initial ioReq = '0;
    // A released bus shows inverted address and data, never the old value.
    task automatic ioAcc(logic wr, logic [15:0] a, logic [7:0] d);
        @(negedge clk);
        ioReq <= {!wr, wr, a, d};
        @(negedge clk);
        ioReq <= {1'b0, 1'b0, ~a, ~d};
    endtask
    task automatic putEntry(vap_rgb_s c);
        ioAcc(1'b1, VAP_DATA_ADDR, c.red);
        ioAcc(1'b1, VAP_DATA_ADDR, c.green);
        ioAcc(1'b1, VAP_DATA_ADDR, c.blue);
    endtask
    task automatic getEntry();
        repeat (3) ioAcc(1'b0, VAP_DATA_ADDR, 8'h00);
    endtask
endmodule
`default_nettype wire

// file: tb/vap_attr_palette_tb.sv
`default_nettype none
module vap_attr_palette_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import vap_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    vap_io_s ioReq;
    logic [7:0] ioRdData;
    logic ioRdValid, rgbValid;
    logic pixEn = 1'b0, lineStart = 1'b0;
    vap_pix_s pixIn = '0;
    logic directMode = 1'b0, cursorSel = 1'b0, nineDot = 1'b0;
    vap_rgb_s rgbOut, ca, cb, cc, cd, dv;
    int errors = 0, compares = 0;
    int seed = 32'hcef48c5e;
    logic [15:0] rdQ[$];
    vap_rgb_s rgbQ[$];
    logic [7:0] v;
    int hiB[4] = '{2, 5, 3, 7};
    int loB[4] = '{0, 4, 1, 6};
    // Each word: mode byte, nine-dot flag, shift code, pixels dropped.
    logic [19:0] pt[7] = '{20'h00101, 20'h00178, 20'h00180, 20'h00077,
        20'h01033, 20'h41063, 20'h41021};
    always #10 clk = ~clk;
    vap_attr_palette uut (.clk(clk), .reset(reset), .ioReq(ioReq),
        .ioRdData(ioRdData), .ioRdValid(ioRdValid), .pixEn(pixEn),
        .lineStart(lineStart), .pixIn(pixIn), .directMode(directMode),
        .cursorTableSel(cursorSel), .nineDot(nineDot), .rgbOut(rgbOut),
        .rgbValid(rgbValid));
    vap_host_model host (.clk(clk), .ioReq(ioReq));
    task automatic checkRd(string n, logic [15:0] e, logic [7:0] s);
        compares++;
        if ((s & e[15:8]) !== (e[7:0] & e[15:8])) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e[7:0], s);
        end
    endtask
    task automatic checkRgb(string n, logic [23:0] e, logic [23:0] s);
        compares++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    always @(negedge clk) begin
        if (ioRdValid === 1'b1)
            checkRd("read", rdQ.size() ? rdQ.pop_front() : 16'hffxx,
                ioRdData);
        if (rgbValid === 1'b1)
            checkRgb("rgb", rgbQ.size() ? rgbQ.pop_front() : 'x,
                rgbOut);
    end
    function automatic vap_rgb_s rnd();
        return vap_rgb_s'(24'($random(seed)));
    endfunction
    task automatic rd(logic [15:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
        rdQ.push_back({m, e});
        host.ioAcc(1'b0, a, 8'h00);
    endtask
    task automatic wr(logic [15:0] a, logic [7:0] d);
        host.ioAcc(1'b1, a, d);
    endtask
    task automatic attr(logic [4:0] i, logic [7:0] d);
        wr(VAP_ATTR_WR_ADDR, {3'h0, i});
        wr(VAP_ATTR_WR_ADDR, d);
    endtask
    task automatic getRgb(vap_rgb_s e);
        rdQ.push_back({8'hff, e.red});
        rdQ.push_back({8'hff, e.green});
        rdQ.push_back({8'hff, e.blue});
        host.getEntry();
    endtask
    task automatic pix(logic [3:0] pl, logic [7:0] ix, logic [23:0] dc,
            logic ls, logic cu = 1'b0);
        @(negedge clk);
        pixEn <= 1'b1;
        lineStart <= ls;
        pixIn <= {pl, ix, dc, cu, ix[2:0]};
    endtask
    task automatic idle();
        @(negedge clk);
        pixEn <= 1'b0;
        lineStart <= 1'b0;
    endtask
    task automatic one(logic [3:0] pl, logic [7:0] ix, logic [23:0] dc,
            vap_rgb_s e, logic cu = 1'b0);
        rgbQ.push_back(e);
        pix(pl, ix, dc, 1'b1, cu);
        idle();
    endtask
    task automatic print_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #400000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk) reset <= 1'b0;
        rd(VAP_MASK_ADDR, VAP_MASK_RST);
        rd(VAP_RIDX_ADDR, 8'h00);
        rd(16'h03c5, 8'h00);
        ca = rnd();
        cb = rnd();
        cc = rnd();
        cd = rnd();
        wr(VAP_WIDX_ADDR, 8'h05);
        host.putEntry(ca);
        wr(VAP_WIDX_ADDR, 8'h05);
        wr(VAP_DATA_ADDR, ~ca.red);
        wr(VAP_DATA_ADDR, ~ca.green);
        wr(VAP_RIDX_ADDR, 8'h05);
        getRgb(ca);
        host.putEntry(cb);
        host.putEntry(cc);
        wr(VAP_RIDX_ADDR, 8'h05);
        rd(VAP_RIDX_ADDR, {6'h00, VAP_STATE_READ});
        getRgb(cb);
        getRgb(cc);
        wr(VAP_RIDX_ADDR, 8'h05);
        wr(VAP_WIDX_ADDR, 8'hff);
        rd(VAP_RIDX_ADDR, {6'h00, VAP_STATE_WRITE});
        wr(VAP_DATA_ADDR, cd.red);
        rd(VAP_DATA_ADDR, cb.red);
        wr(VAP_DATA_ADDR, cd.green);
        wr(VAP_DATA_ADDR, cd.blue);
        rd(VAP_DATA_ADDR, cb.green);
        rd(VAP_DATA_ADDR, cb.blue);
        host.putEntry(ca);
        wr(VAP_RIDX_ADDR, 8'hff);
        getRgb(cd);
        getRgb(ca);
        @(negedge clk) cursorSel <= 1'b1;
        wr(VAP_WIDX_ADDR, 8'h07);
        host.putEntry(cc);
        host.putEntry(cd);
        wr(VAP_RIDX_ADDR, 8'h07);
        getRgb(cc);
        getRgb(cd);
        @(negedge clk) cursorSel <= 1'b0;
        attr(VAP_IDX_MODE, 8'h41);
        one(4'h0, 8'h05, rnd(), cb);
        wr(VAP_MASK_ADDR, 8'hfe);
        one(4'h0, 8'h07, rnd(), cc);
        @(negedge clk) directMode <= 1'b1;
        dv = rnd();
        one(4'h0, 8'h07, dv, dv);
        one(4'h0, 8'h00, rnd(), cd, 1'b1);
        @(negedge clk) directMode <= 1'b0;
        wr(VAP_MASK_ADDR, 8'hff);
        attr(5'h00, 8'h05);
        attr(5'h01, 8'h0f);
        attr(VAP_IDX_PLANE, 8'h0e);
        attr(VAP_IDX_MODE, 8'h01);
        one(4'h1, 8'h00, rnd(), cb);
        attr(VAP_IDX_PLANE, 8'h0f);
        attr(VAP_IDX_MODE, 8'h81);
        attr(VAP_IDX_CSEL, 8'h0f);
        one(4'h1, 8'h00, rnd(), cd);
        // Mask zero pins the lookup to entry 0 while the index stays random.
        attr(VAP_IDX_MODE, 8'h41);
        wr(VAP_MASK_ADDR, 8'h00);
        for (int c = 0; c < 4; c++) begin
            v = 8'($random(seed));
            attr(VAP_IDX_PLANE, {2'h0, 2'(c), 4'hf});
            one(4'h0, v, rnd(), ca);
            rd(VAP_STAT_COLOR_ADDR, {2'h0, v[hiB[c]], v[loB[c]], 4'h0},
                8'h30);
        end
        @(negedge clk) directMode <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            attr(VAP_IDX_MODE, pt[i][19:12]);
            attr(VAP_IDX_SHIFT, {4'h0, pt[i][7:4]});
            @(negedge clk) nineDot <= pt[i][8];
            for (int k = 0; k < 12; k++) begin
                dv = rnd();
                if (k >= pt[i][3:0])
                    rgbQ.push_back(dv);
                pix(4'h0, 8'h00, dv, k == 0);
            end
            idle();
        end
        repeat (6) @(negedge clk);
        checkRgb("pending", 24'h0, 24'(rdQ.size() + rgbQ.size()));
        print_verdict();
    end
endmodule
`default_nettype wire
